// [logic/dcm_regs.svh]
// Offsets, field positions, reset values and limits of the DC motor channel
// Assumes byte addressing on a 32-bit register bus
`ifndef DCM_REGS_SVH
`define DCM_REGS_SVH

// Register byte offsets
`define DCM_A_CTRL     5'h00
`define DCM_A_CONFIG   5'h04
`define DCM_A_DUTY     5'h08
`define DCM_A_SLOT     5'h0C
`define DCM_A_LDSEL    5'h10
`define DCM_A_STATUS   5'h14
`define DCM_A_PERIOD   5'h18
`define DCM_A_ONDELAY  5'h1C

// Control register fields
`define DCM_CTRL_SWGATE 0
`define DCM_CTRL_ISO    1

// Configuration register fields
`define DCM_CFG_MODE    2:0
`define DCM_CFG_FUNC    5:4
`define DCM_CFG_FILT    11:8
`define DCM_CFG_FMT     12
`define DCM_CFG_RESET   32'h0000_0201

// Status register fields
`define DCM_ST_RUN      0
`define DCM_ST_FWD      1
`define DCM_ST_BWD      2
`define DCM_ST_LDERR    3
`define DCM_ST_DIN      4
`define DCM_ST_PULSE    5

// Operating modes and formats
`define DCM_MODE_DCM    3'h5
`define DCM_FMT_ANALOG  1'h0

// Times in microseconds
`define DCM_PER_MIN     27'h000_0064
`define DCM_PER_MAX     27'h510_FF40
`define DCM_PER_RESET   27'h000_03E8
`define DCM_ODL_MAX     27'h510_FF40
`define DCM_ODL_RESET   27'h000_0000

// Filter times in microseconds per code
`define DCM_FLT_0       15'h0004
`define DCM_FLT_1       15'h0032
`define DCM_FLT_2       15'h0064
`define DCM_FLT_3       15'h0190
`define DCM_FLT_4       15'h0320
`define DCM_FLT_5       15'h0640
`define DCM_FLT_6       15'h0C80
`define DCM_FLT_7       15'h3200
`define DCM_FLT_8       15'h4E20

// Full scale of the signed duty value
`define DCM_DUTY_FS     16'h6C00

// Clock rate and the microsecond prescale
`define DCM_CLK_MHZ     200
`define DCM_NS_PER_US   1000
`define DCM_CLK_NS      5

// Bus responses
`define DCM_RESP_OKAY   2'h0
`define DCM_RESP_SLVERR 2'h2

`endif

// [logic/dcm_pkg.sv]
// Types shared by the DC motor channel modules
// Assumes dcm_regs.svh supplies the numeric constants
package dcm_pkg;

  // Sequence states
  typedef enum logic [1:0] {
    DCM_IDLE  = 2'b00,
    DCM_DELAY = 2'b01,
    DCM_RUN   = 2'b10
  } dcm_state_t;

  // Input function codes
  typedef enum logic [1:0] {
    DCM_FN_INPUT = 2'b00,
    DCM_FN_GATE  = 2'b01,
    DCM_FN_STOP  = 2'b10,
    DCM_FN_BAD   = 2'b11
  } dcm_fn_t;

  // Load select codes
  typedef enum logic [3:0] {
    DCM_LD_IDLE   = 4'b0000,
    DCM_LD_PERIOD = 4'b0001,
    DCM_LD_ONDLY  = 4'b0010
  } dcm_ld_t;

endpackage

// [logic/dcm_filter.sv]
// Noise filter for the control input pin
// Assumes a one-cycle microsecond tick from the same clock
`timescale 1ns/10ps
`default_nettype none
`include "dcm_regs.svh"

module dcm_filter
  import dcm_pkg::*;
(
  input  wire logic       aclk,    // System clock
  input  wire logic       aresetn, // Synchronous reset, active low
  input  wire logic       din,     // Raw pin level
  input  wire logic       tick,    // One pulse per microsecond
  input  wire logic [3:0] code,    // Filter time select
  output var  logic       dout     // Filtered level
);

  logic        s1_q;    // First synchroniser stage
  logic        s2_q;    // Second synchroniser stage
  logic [14:0] cnt_q;   // Stable time so far
  logic        out_q;   // Accepted level
  logic [14:0] limit;   // Needed stable time

  // Code to filter time in microseconds
  function automatic logic [14:0] flt_us(input logic [3:0] c);
    case (c)
      4'h0:    flt_us = `DCM_FLT_0;
      4'h1:    flt_us = `DCM_FLT_1;
      4'h2:    flt_us = `DCM_FLT_2;
      4'h3:    flt_us = `DCM_FLT_3;
      4'h4:    flt_us = `DCM_FLT_4;
      4'h5:    flt_us = `DCM_FLT_5;
      4'h6:    flt_us = `DCM_FLT_6;
      4'h7:    flt_us = `DCM_FLT_7;
      default: flt_us = `DCM_FLT_8;
    endcase
  endfunction

  assign limit = flt_us(code);
  assign dout  = out_q;

  // Two-stage synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
    end
  end

  // Accept a level once stable for the selected time, see RULE3
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 15'h0000;
      out_q <= 1'b0;
    end else if (s2_q == out_q) begin
      cnt_q <= 15'h0000;
    end else if (tick) begin
      if (cnt_q + 15'h0001 >= limit) begin
        cnt_q <= 15'h0000;
        out_q <= s2_q;
      end else begin
        cnt_q <= cnt_q + 15'h0001;
      end
    end
  end

endmodule
`default_nettype wire

// [logic/dcm_top.sv]
// DC motor pulse channel with AXI4-Lite configuration registers
// Assumes one clock, synchronous reset, and an asynchronous control pin
// Contract
// RULE1: Mode 5 runs the motor; reset mode is 1
// RULE2: Input function 0 input, 1 gate, 2 stop
// RULE3: Pin change accepted after selected stable time
// RULE4: Gate function starts on pin rise with gate set
// RULE5: Gate function stops on pin fall
// RULE6: Isochronous gate function acts as external stop
// RULE7: External stop starts on software gate rise
// RULE8: External stop ends on pin rise
// RULE9: Duty format 0 is signed analog, the default
// RULE10: Period in microseconds, 100 to 85000000, 1000 default
// RULE11: Host reloads period through the load value
// RULE12: On-delay before first pulse, up to 85000000
// RULE13: Host reloads on-delay through the load value
// RULE14: Pulse drives direction output; gap drives both low
// RULE15: Low 16 duty bits, clamp 27648, sign is direction
// RULE16: Load code 0 idle, 1 period, 2 delay, else error
// RULE17: New period or duty taken at next rising edge
// RULE18: Plain input function leaves the gate bit in control
//
// The AXI4-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "dcm_regs.svh"

module dcm_top
  import dcm_pkg::*;
#(
  parameter int TICK_CYC = `DCM_NS_PER_US / `DCM_CLK_NS // Cycles per us
)(
  input  wire logic        aclk,     // System clock
  input  wire logic        aresetn,  // Synchronous reset, active low
  input  wire logic [4:0]  awaddr,   // Write address
  input  wire logic [2:0]  awprot,   // Write protection, unused
  input  wire logic        awvalid,  // Write address valid
  output var  logic        awready,  // Write address ready
  input  wire logic [31:0] wdata,    // Write data
  input  wire logic [3:0]  wstrb,    // Write byte enables
  input  wire logic        wvalid,   // Write data valid
  output var  logic        wready,   // Write data ready
  output var  logic [1:0]  bresp,    // Write response
  output var  logic        bvalid,   // Write response valid
  input  wire logic        bready,   // Write response ready
  input  wire logic [4:0]  araddr,   // Read address
  input  wire logic [2:0]  arprot,   // Read protection, unused
  input  wire logic        arvalid,  // Read address valid
  output var  logic        arready,  // Read address ready
  output var  logic [31:0] rdata,    // Read data
  output var  logic [1:0]  rresp,    // Read response
  output var  logic        rvalid,   // Read data valid
  input  wire logic        rready,   // Read data ready
  input  wire logic        ctrl_in,  // Control input pin
  output var  logic        forward_drive_output,  // Forward drive level
  output var  logic        forward_drive_oe,      // Forward drive enable
  output var  logic        backward_drive_output, // Backward drive level
  output var  logic        backward_drive_oe      // Backward drive enable
);

  // Register state
  logic [31:0] ctrl_q;     // Gate bit and isochronous bit
  logic [31:0] cfg_q;      // Mode, function, filter, format
  logic [31:0] duty_q;     // Signed duty value
  logic [31:0] slot_q;     // Load value
  logic [3:0]  ldsel_q;    // Load select code
  logic        lderr_q;    // Sticky load error
  logic [26:0] per_cfg_q;  // Configured period, us
  logic [26:0] odl_cfg_q;  // Configured on-delay, us

  // Bus state
  logic        aw_have_q;  // Write address held
  logic        w_have_q;   // Write data held
  logic [4:0]  waddr_q;    // Held write address
  logic [31:0] wdat_q;     // Held write data
  logic [3:0]  wstb_q;     // Held byte enables
  logic        ld_go_q;    // Load select was written

  // Sequence state
  dcm_state_t  st_q;       // Sequence state
  dcm_state_t  st_d;       // Next sequence state
  logic [7:0]  tck_q;      // Microsecond prescaler
  logic [26:0] cnt_q;      // Delay or period position, us
  logic [26:0] per_q;      // Active period, us
  logic [26:0] odl_q;      // Active on-delay, us
  logic [26:0] wid_q;      // Active pulse width, us
  logic        fwd_q;      // Active direction forward
  logic        sw_prev_q;  // Gate bit last cycle
  logic        din_prev_q; // Filtered pin last cycle
  logic        fo_q;       // Forward output register
  logic        bo_q;       // Backward output register
  logic        oe_q;       // Output enable register

  // Named decode wires
  logic        tick;       // One cycle per microsecond
  logic        din_f;      // Filtered pin level
  logic        sw;         // Software gate bit
  logic        iso;        // Isochronous operation
  logic        mode_ok;    // DC motor mode selected
  dcm_fn_t     fn;         // Effective input function
  logic        sw_rise;    // Gate bit 0 to 1
  logic        sw_fall;    // Gate bit 1 to 0
  logic        din_rise;   // Filtered pin 0 to 1
  logic        din_fall;   // Filtered pin 1 to 0
  logic        start_ev;   // Sequence start
  logic        stop_ev;    // Sequence stop
  logic        wr_do;      // Write performed this cycle
  logic        wr_map;     // Write address is mapped
  logic        rd_map;     // Read address is mapped
  logic [31:0] rd_val;     // Read mux
  logic [31:0] wmerge;     // Held data under byte enables, other bytes zero
  logic [15:0] mag;        // Clamped duty magnitude
  logic        dir_fwd;    // Duty sign forward
  logic [26:0] wid_new;    // Width for next period
  logic        per_end;    // Last microsecond of period
  logic        odl_end;    // Last microsecond of delay
  logic        pulse;      // In the pulse phase
  logic        per_ok;     // Load value fits period range
  logic        odl_ok;     // Load value fits delay range

  // Merge held write data into a register under byte enables
  function automatic logic [31:0] strb_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  be);
    for (int i = 0; i < 4; i++) begin
      strb_merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  // Address decode shared by both channels
  function automatic logic addr_map(input logic [4:0] a);
    addr_map = (a == `DCM_A_CTRL)   || (a == `DCM_A_CONFIG) ||
               (a == `DCM_A_DUTY)   || (a == `DCM_A_SLOT)   ||
               (a == `DCM_A_LDSEL)  || (a == `DCM_A_STATUS) ||
               (a == `DCM_A_PERIOD) || (a == `DCM_A_ONDELAY);
  endfunction

  // Pin filter
  dcm_filter u_filter (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (ctrl_in),
    .tick    (tick),
    .code    (cfg_q[`DCM_CFG_FILT]),
    .dout    (din_f)
  );

  // Register field decode
  assign sw      = ctrl_q[`DCM_CTRL_SWGATE];
  assign iso     = ctrl_q[`DCM_CTRL_ISO];
  // Only mode 5 with the analog format drives the motor, see RULE1, RULE9
  assign mode_ok = (cfg_q[`DCM_CFG_MODE] == `DCM_MODE_DCM) &&
                   (cfg_q[`DCM_CFG_FMT] == `DCM_FMT_ANALOG);
  // Gate under isochronous operation is treated as stop, see RULE6
  assign fn = (cfg_q[`DCM_CFG_FUNC] == DCM_FN_GATE && iso) ? DCM_FN_STOP :
              (cfg_q[`DCM_CFG_FUNC] == DCM_FN_BAD) ? DCM_FN_INPUT :
              dcm_fn_t'(cfg_q[`DCM_CFG_FUNC]); // see RULE2

  // Edge detection
  assign sw_rise  = sw && !sw_prev_q;
  assign sw_fall  = !sw && sw_prev_q;
  assign din_rise = din_f && !din_prev_q;
  assign din_fall = !din_f && din_prev_q;

  // Start events per function, see RULE4, RULE7, RULE18
  assign start_ev = mode_ok && (st_q == DCM_IDLE) &&
                    ((fn == DCM_FN_INPUT && sw_rise) ||
                     (fn == DCM_FN_GATE && din_rise && sw) ||
                     (fn == DCM_FN_STOP && sw_rise));
  // Stop events per function, see RULE5, RULE8, RULE18
  assign stop_ev  = !mode_ok || sw_fall ||
                    (fn == DCM_FN_GATE && din_fall) ||
                    (fn == DCM_FN_STOP && din_rise);

  // Duty clamp and direction, see RULE15
  assign dir_fwd = !duty_q[15];
  assign mag = duty_q[15] ?
               (($signed(duty_q[15:0]) < -$signed({1'b0, `DCM_DUTY_FS})) ?
                `DCM_DUTY_FS : 16'(-duty_q[15:0])) :
               ((duty_q[15:0] > `DCM_DUTY_FS) ? `DCM_DUTY_FS : duty_q[15:0]);
  assign wid_new = 27'((43'(mag) * 43'(per_cfg_q)) / 43'(`DCM_DUTY_FS));

  // Timing decode
  assign tick    = (tck_q == 8'(TICK_CYC - 1));
  assign per_end = tick && (cnt_q + 27'h000_0001 >= per_q);
  assign odl_end = tick && (cnt_q + 27'h000_0001 >= odl_q);
  assign pulse   = (st_q == DCM_RUN) && (cnt_q < wid_q);

  // Load value range checks, see RULE10, RULE12
  assign per_ok = (slot_q >= 32'(`DCM_PER_MIN)) &&
                  (slot_q <= 32'(`DCM_PER_MAX));
  assign odl_ok = (slot_q <= 32'(`DCM_ODL_MAX));

  // Bus decode
  assign wr_do  = aw_have_q && w_have_q && !bvalid;
  assign wr_map = addr_map(waddr_q);
  assign rd_map = addr_map(araddr);
  assign wmerge = strb_merge(32'h0000_0000, wdat_q, wstb_q);
  assign rd_val =
    (araddr == `DCM_A_CTRL)    ? ctrl_q :
    (araddr == `DCM_A_CONFIG)  ? cfg_q :
    (araddr == `DCM_A_DUTY)    ? duty_q :
    (araddr == `DCM_A_SLOT)    ? slot_q :
    (araddr == `DCM_A_LDSEL)   ? {28'h000_0000, ldsel_q} :
    (araddr == `DCM_A_STATUS)  ? {26'h000_0000, pulse, din_f, lderr_q,
                                  bo_q, fo_q, oe_q} :
    (araddr == `DCM_A_PERIOD)  ? {5'h00, per_cfg_q} :
    (araddr == `DCM_A_ONDELAY) ? {5'h00, odl_cfg_q} : 32'h0000_0000;

  // Write channels, address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      waddr_q   <= 5'h00;
      wdat_q    <= 32'h0000_0000;
      wstb_q    <= 4'h0;
    end else begin
      // Capture address
      if (awvalid && awready) begin
        aw_have_q <= 1'b1;
        waddr_q   <= awaddr;
      end else if (bvalid && bready) begin
        aw_have_q <= 1'b0;
      end
      // Capture data
      if (wvalid && wready) begin
        w_have_q <= 1'b1;
        wdat_q   <= wdata;
        wstb_q   <= wstrb;
      end else if (bvalid && bready) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // Write ready and response registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= `DCM_RESP_OKAY;
    end else begin
      awready <= !aw_have_q && !(awvalid && awready);
      wready  <= !w_have_q && !(wvalid && wready);
      if (wr_do) begin
        bvalid <= 1'b1;
        bresp  <= wr_map ? `DCM_RESP_OKAY : `DCM_RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Read channel, one answer per address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= `DCM_RESP_OKAY;
    end else begin
      arready <= !rvalid && !(arvalid && arready);
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata  <= rd_val;
        rresp  <= rd_map ? `DCM_RESP_OKAY : `DCM_RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // Software-written registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q  <= 32'h0000_0000;
      cfg_q   <= `DCM_CFG_RESET;
      duty_q  <= 32'h0000_0000;
      slot_q  <= 32'h0000_0000;
      ldsel_q <= DCM_LD_IDLE;
      ld_go_q <= 1'b0;
    end else begin
      ld_go_q <= wr_do && (waddr_q == `DCM_A_LDSEL) && wstb_q[0];
      if (wr_do && waddr_q == `DCM_A_CTRL)
        ctrl_q <= strb_merge(ctrl_q, wdat_q, wstb_q) & 32'h0000_0003;
      if (wr_do && waddr_q == `DCM_A_CONFIG)
        cfg_q <= strb_merge(cfg_q, wdat_q, wstb_q) & 32'h0000_1F37;
      if (wr_do && waddr_q == `DCM_A_DUTY)
        duty_q <= strb_merge(duty_q, wdat_q, wstb_q);
      if (wr_do && waddr_q == `DCM_A_SLOT)
        slot_q <= strb_merge(slot_q, wdat_q, wstb_q);
      if (wr_do && waddr_q == `DCM_A_LDSEL && wstb_q[0])
        ldsel_q <= wmerge[3:0];
    end
  end

  // Load value into period or on-delay, see RULE11, RULE13, RULE16
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      per_cfg_q <= `DCM_PER_RESET;
      odl_cfg_q <= `DCM_ODL_RESET;
      lderr_q   <= 1'b0;
    end else begin
      if (ld_go_q && ldsel_q == DCM_LD_PERIOD && per_ok)
        per_cfg_q <= slot_q[26:0];
      if (ld_go_q && ldsel_q == DCM_LD_ONDLY && odl_ok)
        odl_cfg_q <= slot_q[26:0];
      // Error set wins over write-one clear
      if (ld_go_q && ((ldsel_q == DCM_LD_PERIOD && !per_ok) ||
                      (ldsel_q == DCM_LD_ONDLY && !odl_ok) ||
                      (ldsel_q != DCM_LD_IDLE && ldsel_q != DCM_LD_PERIOD &&
                       ldsel_q != DCM_LD_ONDLY)))
        lderr_q <= 1'b1;
      else if (wr_do && waddr_q == `DCM_A_STATUS &&
               wmerge[`DCM_ST_LDERR])
        lderr_q <= 1'b0;
    end
  end

  // Next sequence state, stop before start
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      DCM_IDLE: begin
        if (start_ev && !stop_ev)
          st_d = (odl_cfg_q == 27'h000_0000) ? DCM_RUN : DCM_DELAY;
      end
      DCM_DELAY: begin
        if (stop_ev)
          st_d = DCM_IDLE;
        else if (odl_end)
          st_d = DCM_RUN;
      end
      DCM_RUN: begin
        if (stop_ev)
          st_d = DCM_IDLE;
      end
    endcase
  end

  // Prescaler and edge history
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tck_q      <= 8'h00;
      sw_prev_q  <= 1'b0;
      din_prev_q <= 1'b0;
    end else begin
      tck_q      <= tick ? 8'h00 : tck_q + 8'h01;
      sw_prev_q  <= sw;
      din_prev_q <= din_f;
    end
  end

  // Sequence timing; new values taken at each rising edge, see RULE17
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q  <= DCM_IDLE;
      cnt_q <= 27'h000_0000;
      per_q <= `DCM_PER_RESET;
      odl_q <= `DCM_ODL_RESET;
      wid_q <= 27'h000_0000;
      fwd_q <= 1'b1;
    end else begin
      st_q <= st_d;
      // On-delay latched at sequence start, see RULE12
      if (st_q == DCM_IDLE)
        odl_q <= odl_cfg_q;
      if (st_d == DCM_RUN && (st_q != DCM_RUN || per_end)) begin
        cnt_q <= 27'h000_0000;
        per_q <= per_cfg_q;
        wid_q <= wid_new;
        fwd_q <= dir_fwd;
      end else if (st_d == DCM_IDLE || st_d != st_q) begin
        cnt_q <= 27'h000_0000;
      end else if (tick) begin
        cnt_q <= cnt_q + 27'h000_0001;
      end
    end
  end

  // Drive outputs, released when stopped, see RULE14
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fo_q <= 1'b0;
      bo_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      fo_q <= pulse && fwd_q;
      bo_q <= pulse && !fwd_q;
      oe_q <= (st_q != DCM_IDLE);
    end
  end

  assign forward_drive_output  = fo_q;
  assign backward_drive_output = bo_q;
  assign forward_drive_oe      = oe_q;
  assign backward_drive_oe     = oe_q;

endmodule
`default_nettype wire

// [verification/dcm_pin_src.sv]
// Sensor model driving the control input pin
// Assumes the bench sets the level after a clock edge
`timescale 1ns/10ps
`default_nettype none

module dcm_pin_src (
  input  wire logic lvl,    // Wanted sensor level
  output wire logic ctrl_in // Pin level seen by the channel
);
  // Pin moves off the clock edge, like a field signal
  assign #1.3 ctrl_in = lvl;
endmodule
`default_nettype wire

// [verification/dcm_top_properties.sv]
// Port properties of the DC motor channel
// Assumes a bind onto dcm_top, synchronous active-low reset
`timescale 1ns/10ps
`default_nettype none

module dcm_top_properties (
  input wire logic        aclk,                  // Clock
  input wire logic        aresetn,               // Reset, active low
  input wire logic        awvalid,               // Address valid
  input wire logic        awready,               // Address ready
  input wire logic        wvalid,                // Data valid
  input wire logic        wready,                // Data ready
  input wire logic        bvalid,                // Response valid
  input wire logic        bready,                // Response ready
  input wire logic        arvalid,               // Read address valid
  input wire logic        arready,               // Read address ready
  input wire logic [31:0] rdata,                 // Read data
  input wire logic        rvalid,                // Read valid
  input wire logic        rready,                // Read ready
  input wire logic        forward_drive_output,  // Forward level
  input wire logic        forward_drive_oe,      // Forward enable
  input wire logic        backward_drive_output, // Backward level
  input wire logic        backward_drive_oe      // Backward enable
);
  // One clock domain
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_drive_excl:
    assert property (!(forward_drive_output && backward_drive_output))
    else $error("Both drive outputs high");
  a_gap_low:
    assert property (!forward_drive_oe |-> !forward_drive_output
      && !backward_drive_output && !backward_drive_oe)
    else $error("Drive level while released");
  a_b_hold:
    assert property (bvalid && !bready |=> bvalid)
    else $error("Write response dropped early");
  a_r_hold:
    assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("Read data dropped early");
  a_r_answer:
    assert property (arvalid && arready |=> rvalid)
    else $error("Read answer late");
  a_ar_block:
    assert property (rvalid |-> !arready)
    else $error("Read address taken while busy");
  a_b_answer:
    assert property (awvalid && awready && wvalid && wready
      |=> ##[0:1] bvalid)
    else $error("Write answer late");
  a_reset_quiet:
    assert property ($rose(aresetn) |-> !forward_drive_oe && !bvalid
      && !rvalid && !awready)
    else $error("Outputs active right after reset");
endmodule
`default_nettype wire

// [verification/tb_dc_motor_pwm_config.sv]
// Self-checking bench of the DC motor channel
// Assumes design, pin source and checker compiled first
`timescale 1ns/10ps
`default_nettype none
`include "dcm_regs.svh"

module tb_dc_motor_pwm_config;
  localparam int TK = 2;             // Cycles per microsecond
  logic        aclk = 0;             // Clock
  logic        aresetn = 0;          // Reset, active low
  logic [4:0]  awaddr = 0;           // Write address
  logic [4:0]  araddr = 0;           // Read address
  logic [31:0] wdata = 0;            // Write data
  logic        awvalid = 0, wvalid = 0, bready = 0;
  logic        arvalid = 0, rready = 0, lvl = 0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;         // Responses
  logic [31:0] rdata, g;             // Read data, last read
  logic        forward_drive_output, forward_drive_oe;
  logic        backward_drive_output, backward_drive_oe;
  wire logic   ctrl_in;              // Pin from the source
  int          error_cnt = 0, checked = 0;
  int          mp = 1000, mo = 0, me = 0, seed = 50, w;
  logic [31:0] dt [2] = '{32'hFFFF_3600, 32'h0000_E500}; // Duties

  always #2.5 aclk = ~aclk;

  dcm_top #(.TICK_CYC(TK)) DUT (.aclk, .aresetn, .awaddr, .awprot(3'h0),
    .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .ctrl_in, .forward_drive_output,
    .forward_drive_oe, .backward_drive_output, .backward_drive_oe);
  dcm_pin_src u_pin (.lvl, .ctrl_in);

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic end_of_test;
    if (error_cnt == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic tmo;
    error_cnt++;
    end_of_test;
  endtask

  // Bus write
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && n < 200);
    bready <= 1'b0;
    if (n >= 200) tmo;
  endtask

  // Bus read
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 200);
    d = rdata;
    rready <= 1'b0;
    if (n >= 200) tmo;
  endtask

  // Slot load, compared with the model
  task automatic ld(input int c, input int v);
    wr(`DCM_A_SLOT, 32'(v));
    wr(`DCM_A_LDSEL, 32'(c));
    if (c == 1 && v >= 100 && v <= 85000000)
      mp = v;
    else if (c == 2 && v <= 85000000)
      mo = v;
    else if (c != 0)
      me = 1;
    rd(`DCM_A_PERIOD, g);
    chk(g, 32'(mp));
    rd(`DCM_A_ONDELAY, g);
    chk(g, 32'(mo));
    rd(`DCM_A_STATUS, g);
    chk(32'(g[3]), 32'(me));
    wr(`DCM_A_STATUS, 32'h0000_0008);
    me = 0;
  endtask

  task automatic cfg(input int f);
    wr(`DCM_A_CONFIG, 32'(f * 16 + 5));
  endtask

  task automatic oe(input logic e);
    repeat (4) @(posedge aclk);
    chk(32'(forward_drive_oe), 32'(e));
  endtask

  task automatic pin(input logic v);
    lvl <= v;
    repeat (40) @(posedge aclk);
  endtask

  // Expected pulse width in cycles
  function automatic int wid(input logic [31:0] v);
    int d;
    d = int'($signed(v[15:0]));
    if (d > 27648) d = 27648;
    if (d < -27648) d = -27648;
    return (d < 0 ? -d : d) * mp / 27648 * TK;
  endfunction

  function automatic logic drv(input logic [31:0] v);
    return v[15] ? backward_drive_output : forward_drive_output;
  endfunction

  // Cycles the selected output keeps a level
  task automatic hold(input logic [31:0] v, input logic l, output int n);
    n = 0;
    while (drv(v) === l && n < 900) begin
      @(posedge aclk);
      n++;
    end
    if (n >= 900) tmo;
  endtask

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(`DCM_A_CONFIG, g);
    chk(g, `DCM_CFG_RESET);
    rd(`DCM_A_PERIOD, g);
    chk(g, 32'(mp));
    rd(`DCM_A_ONDELAY, g);
    chk(g, 32'(mo));
    for (int c = 0; c < 9; c++) begin
      wr(`DCM_A_CONFIG, 32'(c * 256 + 5));
      rd(`DCM_A_CONFIG, g);
      chk(g, 32'(c * 256 + 5));
    end
    for (int m = 0; m < 6; m++) begin
      wr(`DCM_A_CONFIG, m < 5 ? 32'(m) : 32'h0000_1005);
      wr(`DCM_A_CTRL, 32'h0000_0001);
      oe(0);
      wr(`DCM_A_CTRL, 32'h0000_0000);
    end
    ld(1, 85000001);
    ld(1, 99);
    ld(3, 5);
    ld(0, 7);
    ld(2, 85000001);
    ld(1, 85000000);
    ld(1, 100);
    ld(2, ($random(seed) & 15) + 1);
    cfg(0);
    foreach (dt[i]) begin
      wr(`DCM_A_DUTY, dt[i]);
      wr(`DCM_A_CTRL, 32'h0000_0001);
      hold(dt[i], 1'b1, w);
      hold(dt[i], 1'b0, w);
      hold(dt[i], 1'b1, w);
      chk(32'(w), 32'(wid(dt[i])));
      wr(`DCM_A_CTRL, 32'h0000_0000);
      oe(0);
    end
    wr(`DCM_A_CTRL, 32'h0000_0001);
    pin(1);
    oe(1);
    pin(0);
    wr(`DCM_A_CTRL, 32'h0000_0000);
    oe(0);
    cfg(1);
    wr(`DCM_A_CTRL, 32'h0000_0001);
    oe(0);
    lvl <= 1'b1;
    repeat (3) @(posedge aclk);
    pin(0);
    oe(0);
    pin(1);
    oe(1);
    pin(0);
    oe(0);
    wr(`DCM_A_CTRL, 32'h0000_0000);
    for (int i = 0; i < 2; i++) begin
      cfg(2 - i);
      wr(`DCM_A_CTRL, 32'(i * 2 + 1));
      oe(1);
      pin(1);
      oe(0);
      pin(0);
      wr(`DCM_A_CTRL, 32'(i * 2));
    end
    end_of_test;
  end
endmodule

bind dcm_top dcm_top_properties u_props (.aclk, .aresetn, .awvalid,
  .awready, .wvalid, .wready, .bvalid, .bready, .arvalid, .arready, .rdata,
  .rvalid, .rready, .forward_drive_output, .forward_drive_oe,
  .backward_drive_output, .backward_drive_oe);
`default_nettype wire
